// ### rtl/nacs_pkg.sv
// Contract
// - Block erase sets every byte of the addressed 64-page block to FFh.
// - Block erase is rejected unless the write enable latch is set.
// - Erase runs only if chip select rises right after the last address bit.
// - Erase, program execute and page read run self-timed after chip select rises.
// - Busy reads 1 during a self-timed cycle and 0 once it completes.
// - Status register reads stay serviced while a self-timed cycle runs.
// - Write enable latch clears when an erase or program execute finishes.
// - Erase or program execute to a protected block is skipped.
// - Load instructions 02h and 84h are accepted only with the latch set.
// - Load carries a 16-bit column, low twelve bits used, then data bytes.
// - Data bytes beyond the 2176-byte buffer are discarded.
// - Full load fills unwritten bytes with FFh; random load keeps them.
// - With ECC on, parity bytes of the spare area are overwritten.
// - Quad loads 32h and 34h take data bytes on all four IO lines.
// - Write-protect-enable set disables every quad data instruction.
// - Program execute 10h with 24-bit page address writes the buffer there.
// - Page data read 13h copies the addressed page into the buffer.
// - Buffer content stays available for several successive buffer reads.
// - Write enable 06h sets the write enable latch.
// - Status read 0Fh/05h takes an address byte, returns the byte MSB first.
//
// Purpose: constants and carriers of the NAND array command sequencer.
// Assumes: one serial link, one system clock of 125 MHz.
// Notes:   self-timed durations are defaults for simulation only.
package nacs_pkg;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ERASE  = 8'hD8;
  localparam logic [7:0] OP_LOAD   = 8'h02;
  localparam logic [7:0] OP_RLOAD  = 8'h84;
  localparam logic [7:0] OP_QLOAD  = 8'h32;
  localparam logic [7:0] OP_QRLOAD = 8'h34;
  localparam logic [7:0] OP_PEXEC  = 8'h10;
  localparam logic [7:0] OP_PREAD  = 8'h13;
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_RDSR_A = 8'h0F;
  localparam logic [7:0] OP_RDSR_B = 8'h05;
  // ---------------------------------------------------------------
  // Geometry and buffer
  // ---------------------------------------------------------------
  localparam int unsigned BUF_BYTES   = 2176;
  localparam logic [11:0] BUF_END     = 12'h880;
  localparam logic [11:0] ECC_PAR_LO  = 12'h860;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  localparam logic [12:0] NUM_BLOCKS  = 13'h0800;
  localparam int unsigned BLK_LSB     = 6;
  localparam logic [2:0]  EXEC_BYTES  = 3'h4;
  localparam logic [2:0]  DATA_IDX    = 3'h3;
  // ---------------------------------------------------------------
  // Status byte layout; select nibble is the address high nibble
  // ---------------------------------------------------------------
  localparam logic [3:0] SR1_NIB      = 4'hA;
  localparam logic [3:0] SR2_NIB      = 4'hB;
  localparam logic [3:0] SR3_NIB      = 4'hC;
  localparam int unsigned SR1_BP_LSB  = 3;
  localparam int unsigned SR1_TS_BIT  = 2;
  localparam int unsigned SR1_WPE_BIT = 1;
  localparam int unsigned SR2_ECC_BIT = 4;
  localparam int unsigned SR3_WE_BIT  = 1;
  localparam int unsigned SR3_BSY_BIT = 0;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned ERASE_TIME_US  = 2000;
  localparam int unsigned PROG_TIME_US   = 250;
  localparam int unsigned PREAD_TIME_US  = 25;
  localparam int unsigned PREAD_CYC      = PREAD_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 24;
  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic block_protect_bit3;
    logic block_protect_bit2;
    logic block_protect_bit1;
    logic block_protect_bit0;
    logic top_bottom_select;
    logic wp_enable;
    logic ecc_enable;
  } nacs_cfg_s;
  typedef struct packed {
    logic        erase;
    logic        wr;
    logic        rd;
    logic [23:0] page;
    logic [11:0] col;
    logic [7:0]  wdata;
  } nacs_arr_s;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_READ} nacs_state_e;
endpackage

// ### rtl/nacs_top.sv
// Purpose: serial command front end and self-timed array sequencer.
// Assumes: sclk idles between frames; array answers a read next cycle.
// Notes:   page buffer kept in flops; array itself sits outside.
`timescale 1ns/1ns
module nacs_top
  import nacs_pkg::*;
#(
  parameter int unsigned ERASE_CYC = ERASE_TIME_US * CLK_MHZ,
  parameter int unsigned PROG_CYC  = PROG_TIME_US * CLK_MHZ
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic [3:0] io_in,
  output logic [3:0]      io_out,
  output logic [3:0]      io_oe_out,
  input  wire nacs_cfg_s  cfg_in,
  output logic            busy_out,
  output logic            write_enable_latch_out,
  output nacs_arr_s       arr_out,
  input  wire logic [7:0] arr_rdata_in
);

  // ---------------------------------------------------------------
  // Opcode decoding
  // ---------------------------------------------------------------
  function automatic logic is_qload(input logic [7:0] op);
    return (op == OP_QLOAD) || (op == OP_QRLOAD);
  endfunction

  function automatic logic is_load(input logic [7:0] op);
    return is_qload(op) || (op == OP_LOAD) || (op == OP_RLOAD);
  endfunction

  function automatic logic is_full(input logic [7:0] op);
    return (op == OP_LOAD) || (op == OP_QLOAD);
  endfunction

  function automatic logic prot_hit(input logic [10:0] blk,
                                    input nacs_cfg_s   c);
    logic [3:0]  bp;
    logic [12:0] n;
    bp = {c.block_protect_bit3, c.block_protect_bit2,
          c.block_protect_bit1, c.block_protect_bit0};
    n = (bp == 4'h0) ? 13'h0000 :
        (bp >= 4'hC) ? NUM_BLOCKS : (13'h0001 << (bp - 4'h1));
    if (c.top_bottom_select) begin
      return {2'b00, blk} < n;
    end
    return {2'b00, blk} >= (NUM_BLOCKS - n);
  endfunction

  // ---------------------------------------------------------------
  // Link domain: deserialiser and status shifter
  // ---------------------------------------------------------------
  logic [2:0]  lk_bit_reg;
  logic [2:0]  lk_byte_reg;
  logic [5:0]  lk_tot_reg;
  logic        lk_par_reg;
  logic [7:0]  lk_sh_reg;
  logic [7:0]  lk_op_reg;
  logic [7:0]  lk_adr_reg;
  logic [7:0]  lk_dat_reg;
  logic        lk_len_reg;
  logic [23:0] lk_st1_reg;
  logic [23:0] lk_st2_reg;
  logic [1:0]  lk_wpe_reg;
  logic        lk_so_reg;
  logic        lk_oe_reg;
  logic        lk_quad;
  logic [2:0]  lk_bit_next;
  logic [7:0]  lk_sh_next;
  logic        lk_done;
  logic [7:0]  lk_stsel;
  logic [23:0] stat_reg;

  // Quad data phase only after opcode and column; off when protected
  assign lk_quad = (lk_byte_reg >= DATA_IDX) && is_qload(lk_op_reg) && !lk_wpe_reg[1];
  assign lk_bit_next = lk_bit_reg + (lk_quad ? 3'h4 : 3'h1);
  assign lk_sh_next = lk_quad ? {lk_sh_reg[3:0], io_in} : {lk_sh_reg[6:0], io_in[0]};
  assign lk_done = (lk_bit_next == 3'h0);

  // Counters clear while deselected, so every frame starts at bit 0
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      lk_bit_reg  <= 3'h0;
      lk_byte_reg <= 3'h0;
      lk_tot_reg  <= 6'h00;
      lk_par_reg  <= 1'b0;
    end else begin
      lk_bit_reg <= lk_bit_next;
      if (lk_done && lk_byte_reg != 3'h7) begin
        lk_byte_reg <= lk_byte_reg + 3'h1;
      end
      if (lk_done) begin
        lk_par_reg <= ~lk_par_reg;
      end
      if (lk_tot_reg != 6'h3F) begin
        lk_tot_reg <= lk_tot_reg + 6'h01;
      end
    end
  end

  // Byte holding; a byte stays put for a full byte time
  always_ff @(posedge sclk_in) begin
    lk_sh_reg  <= lk_sh_next;
    lk_len_reg <= (lk_tot_reg == 6'h1F);
    if (lk_done) begin
      lk_dat_reg <= lk_sh_next;
    end
    if (lk_done && lk_byte_reg == 3'h0) begin
      lk_op_reg <= lk_sh_next;
    end
    if (lk_done && lk_byte_reg == 3'h1) begin
      lk_adr_reg <= lk_sh_next;
    end
  end

  // Status bits are independent flags, so per-bit level sync is safe
  always_ff @(posedge sclk_in) begin
    lk_st1_reg <= stat_reg;
    lk_st2_reg <= lk_st1_reg;
    lk_wpe_reg <= {lk_wpe_reg[0], cfg_in.wp_enable};
  end

  // Status byte selected by the address high nibble
  always_comb begin
    unique case (lk_adr_reg[7:4])
      SR1_NIB: lk_stsel = lk_st2_reg[23:16];
      SR2_NIB: lk_stsel = lk_st2_reg[15:8];
      SR3_NIB: lk_stsel = lk_st2_reg[7:0];
      default: lk_stsel = 8'h00;
    endcase
  end

  // Served here, apart from the sequencer, so busy never blocks it
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      lk_oe_reg <= 1'b0;
      lk_so_reg <= 1'b0;
    end else begin
      lk_oe_reg <= (lk_byte_reg >= 3'h2) &&
                   (lk_op_reg == OP_RDSR_A || lk_op_reg == OP_RDSR_B);
      lk_so_reg <= lk_stsel[3'h7 - lk_bit_reg];
    end
  end

  // Serial output on IO1 only
  assign io_out    = {2'b00, lk_so_reg, 1'b0};
  assign io_oe_out = {2'b00, lk_oe_reg & ~cs_n_in, 1'b0};

  // ---------------------------------------------------------------
  // Crossing into the system clock
  // ---------------------------------------------------------------
  logic [2:0] sy_raw;
  logic [2:0] sy_lvl;
  logic [2:0] sy_mid;
  localparam logic [2:0] SY_INIT = 3'b100;

  assign sy_raw = {cs_n_in, lk_par_reg, lk_len_reg};

  // Three stages; a change counts once stages two and three agree
  genvar g;
  for (g = 0; g < 3; g++) begin : g_sync
    logic [2:0] s_reg;
    logic       lvl_reg;
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        s_reg   <= {3{SY_INIT[g]}};
        lvl_reg <= SY_INIT[g];
      end else begin
        s_reg <= {s_reg[1:0], sy_raw[g]};
        if (s_reg[1] == s_reg[2]) begin
          lvl_reg <= s_reg[2];
        end
      end
    end
    assign sy_lvl[g] = lvl_reg;
    assign sy_mid[g] = s_reg[1];
  end

  // ---------------------------------------------------------------
  // Frame decode
  // ---------------------------------------------------------------
  logic        cs_ref_reg;
  logic        par_ref_reg;
  logic        byte_ev;
  logic        fe;
  logic [7:0]  b;
  logic [2:0]  idx_reg;
  logic [7:0]  op_reg;
  logic [23:0] adr_reg;
  logic [11:0] col_reg;
  logic [11:0] wcol;
  logic        load_ok_reg;
  logic        ld_go;
  logic        full_go;
  logic        wr_en;
  logic        ecc_go;
  logic [7:0]  ecc_acc_reg;
  logic        wel_reg;
  nacs_state_e st_reg;

  // Early stage of chip select masks the parity reset at frame end
  assign byte_ev = !sy_lvl[2] && !sy_mid[2] && (sy_lvl[1] != par_ref_reg);
  assign fe      = sy_lvl[2] && !cs_ref_reg;
  assign b       = lk_dat_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cs_ref_reg  <= 1'b1;
      par_ref_reg <= 1'b0;
    end else begin
      cs_ref_reg  <= sy_lvl[2];
      par_ref_reg <= sy_lvl[1];
    end
  end

  // Byte position within the frame
  always_ff @(posedge clk_in) begin
    if (rst_in || sy_lvl[2]) begin
      idx_reg <= 3'h0;
    end else if (byte_ev && idx_reg != 3'h7) begin
      idx_reg <= idx_reg + 3'h1;
    end
  end

  // Opcode and address capture; address frozen while busy so status polls keep the page
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      op_reg  <= 8'h00;
      adr_reg <= 24'h000000;
    end else if (byte_ev) begin
      if (idx_reg == 3'h0) begin
        op_reg <= b;
      end else if (idx_reg <= DATA_IDX && st_reg == ST_IDLE) begin
        adr_reg <= {adr_reg[15:0], b};
      end
    end
  end

  // Load acceptance and buffer column
  assign ld_go = byte_ev && idx_reg == 3'h0 && is_load(b) && wel_reg &&
                 st_reg == ST_IDLE && !(is_qload(b) && cfg_in.wp_enable);
  assign full_go = ld_go && is_full(b);
  assign wcol  = (idx_reg == DATA_IDX) ? adr_reg[11:0] : col_reg;
  assign wr_en = byte_ev && load_ok_reg && idx_reg >= DATA_IDX && wcol < BUF_END;
  assign ecc_go = fe && load_ok_reg && cfg_in.ecc_enable;

  always_ff @(posedge clk_in) begin
    if (rst_in || fe) begin
      load_ok_reg <= 1'b0;
    end else if (ld_go) begin
      load_ok_reg <= 1'b1;
    end
  end

  // Column sticks at the end so extra bytes fall away
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      col_reg <= 12'h000;
    end else if (byte_ev && load_ok_reg && idx_reg >= DATA_IDX) begin
      col_reg <= wr_en ? wcol + 12'h001 : wcol;
    end
  end

  // Parity stand-in: running xor of the loaded bytes
  always_ff @(posedge clk_in) begin
    if (rst_in || ld_go) begin
      ecc_acc_reg <= 8'h00;
    end else if (wr_en) begin
      ecc_acc_reg <= ecc_acc_reg ^ b;
    end
  end

  // ---------------------------------------------------------------
  // Self-timed sequencer
  // ---------------------------------------------------------------
  logic [CNT_W-1:0]     cnt_reg;
  logic [CNT_W-1:0]     dur_reg;
  logic                 ex_ok;
  logic                 done;

  // Exactly four bytes and no stray bits, idle; latch and protection for erase and program execute only
  assign ex_ok = fe && idx_reg == EXEC_BYTES && sy_lvl[0] && st_reg == ST_IDLE &&
                 (op_reg == OP_PREAD ||
                  ((op_reg == OP_ERASE || op_reg == OP_PEXEC) && wel_reg &&
                   !prot_hit(adr_reg[BLK_LSB+10:BLK_LSB], cfg_in)));
  assign done  = (st_reg != ST_IDLE) && (cnt_reg == dur_reg - 1'b1);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg  <= ST_IDLE;
      cnt_reg <= '0;
      dur_reg <= '0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          cnt_reg <= '0;
          if (ex_ok) begin
            unique case (op_reg)
              OP_ERASE: begin
                st_reg  <= ST_ERASE;
                dur_reg <= CNT_W'(ERASE_CYC);
              end
              OP_PEXEC: begin
                st_reg  <= ST_PROG;
                dur_reg <= CNT_W'(PROG_CYC);
              end
              default: begin
                st_reg  <= ST_READ;
                dur_reg <= CNT_W'(PREAD_CYC);
              end
            endcase
          end
        end
        ST_ERASE, ST_PROG, ST_READ: begin
          if (done) begin
            st_reg <= ST_IDLE;
          end
          cnt_reg <= cnt_reg + 1'b1;
        end
      endcase
    end
  end

  assign busy_out = (st_reg != ST_IDLE);

  // Latch: set or cleared only while idle, cleared at cycle end
  always_ff @(posedge clk_in) begin
    if (rst_in || done) begin
      wel_reg <= 1'b0;
    end else if (byte_ev && idx_reg == 3'h0 && st_reg == ST_IDLE) begin
      if (b == OP_WREN) begin
        wel_reg <= 1'b1;
      end else if (b == OP_WRDI) begin
        wel_reg <= 1'b0;
      end
    end
  end

  assign write_enable_latch_out = wel_reg;

  // Snapshot of status bytes for the link side
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stat_reg <= 24'h000000;
    end else begin
      stat_reg <= 24'h000000;
      stat_reg[16+SR1_BP_LSB +: 4] <= {cfg_in.block_protect_bit3, cfg_in.block_protect_bit2,
                                       cfg_in.block_protect_bit1, cfg_in.block_protect_bit0};
      stat_reg[16+SR1_TS_BIT]  <= cfg_in.top_bottom_select;
      stat_reg[16+SR1_WPE_BIT] <= cfg_in.wp_enable;
      stat_reg[8+SR2_ECC_BIT]  <= cfg_in.ecc_enable;
      stat_reg[SR3_WE_BIT]     <= wel_reg;
      stat_reg[SR3_BSY_BIT]    <= busy_out;
    end
  end

  // ---------------------------------------------------------------
  // Array port and page buffer
  // ---------------------------------------------------------------
  logic [7:0]  pbuf_reg [BUF_BYTES];
  logic        in_buf;
  logic        rd_d_reg;
  logic [11:0] rdc_d_reg;

  assign in_buf = (cnt_reg < CNT_W'(BUF_BYTES));

  // One command per cycle; bytes stream out early in the cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      arr_out <= '0;
    end else begin
      arr_out       <= '0;
      arr_out.page  <= adr_reg;
      arr_out.col   <= cnt_reg[11:0];
      arr_out.erase <= (st_reg == ST_ERASE) && (cnt_reg == '0);
      arr_out.wr    <= (st_reg == ST_PROG) && in_buf;
      arr_out.rd    <= (st_reg == ST_READ) && in_buf;
      arr_out.wdata <= in_buf ? pbuf_reg[cnt_reg[11:0]] : 8'h00;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_d_reg  <= 1'b0;
      rdc_d_reg <= 12'h000;
    end else begin
      rd_d_reg  <= arr_out.rd;
      rdc_d_reg <= arr_out.col;
    end
  end

  // Buffer is kept between operations for repeated reads
  always_ff @(posedge clk_in) begin
    if (full_go) begin
      for (int i = 0; i < BUF_BYTES; i++) begin
        pbuf_reg[i] <= ERASED_BYTE;
      end
    end
    if (ecc_go) begin
      for (int i = int'(ECC_PAR_LO); i < BUF_BYTES; i++) begin
        pbuf_reg[i] <= ecc_acc_reg;
      end
    end
    if (wr_en) begin
      pbuf_reg[wcol] <= b;
    end
    if (rd_d_reg) begin
      pbuf_reg[rdc_d_reg] <= arr_rdata_in;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_erase_wel;
    (st_reg == ST_IDLE) ##1 (st_reg == ST_ERASE) |-> $past(wel_reg);
  endproperty
  a_erase_wel: assert property (p_erase_wel) else $error("erase without latch");

  property p_erase_len;
    $rose(busy_out) |-> $past(idx_reg) == EXEC_BYTES && $past(sy_lvl[0]);
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("exec with bad length");

  property p_busy_end;
    $fell(busy_out) |-> $past(cnt_reg) == $past(dur_reg) - 1'b1;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("cycle ended early");

  property p_busy_start;
    ex_ok |=> busy_out ##1 busy_out;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised");

  property p_wel_clr;
    busy_out && done |=> !wel_reg;
  endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared");

  property p_prot;
    $rose(busy_out) && st_reg != ST_READ |-> !prot_hit($past(adr_reg[BLK_LSB+10:BLK_LSB]), $past(cfg_in));
  endproperty
  a_prot: assert property (p_prot) else $error("protected block touched");

  property p_load_wel;
    $rose(load_ok_reg) |-> $past(wel_reg) && !$past(busy_out);
  endproperty
  a_load_wel: assert property (p_load_wel) else $error("load without latch");

  property p_cap;
    byte_ev && load_ok_reg && idx_reg > DATA_IDX && col_reg >= BUF_END |=> $stable(col_reg);
  endproperty
  a_cap: assert property (p_cap) else $error("write past buffer");

  property p_quad;
    $rose(load_ok_reg) && is_qload(op_reg) |-> !$past(cfg_in.wp_enable);
  endproperty
  a_quad: assert property (p_quad) else $error("quad load while protected");

  property p_ignore;
    busy_out && fe && !done |=> $stable(dur_reg);
  endproperty
  a_ignore: assert property (p_ignore) else $error("command taken while busy");

endmodule

// ### verif/nacs_host_model.sv
// Purpose: host side of the serial link, sends whole frames.
// Assumes: single bits at 6 ns sclk, quad nibbles at 24 ns.
// Notes:   sclk stands still and lines flip between frames.
`timescale 1ns/1ns
module nacs_host_model (
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic [3:0]      io_out,
  input  wire logic [3:0] io_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io_out = 4'h0;
  end
  // Bytes MSB first; from byte qf on, nibbles on all four lines
  task automatic frame(input logic [7:0] b[$], input int qf, output logic [7:0] rx);
    int hp;
    int k;
    k = 0;
    rx = 8'h00;
    cs_n_out = 1'b0;
    #10;
    foreach (b[i]) begin
      hp = (i >= qf) ? 12 : 3;
      for (int n = 7; n >= 0; n = n - ((i >= qf) ? 4 : 1)) begin
        io_out = (i >= qf) ? b[i][n -: 4] : {~io_out[3:1], b[i][n]};
        #hp sclk_out = 1'b1;
        if (k >= 16 && k < 24) rx = {rx[6:0], io_in[1]};
        k = k + 1;
        #hp sclk_out = 1'b0;
      end
    end
    // Trailing hold lets the last byte clear the device's sync filter first
    #40 cs_n_out = 1'b1;
    io_out = ~io_out;
    // Gap keeps the device's sync chains clear and lets busy settle before the bench checks it
    #80;
  endtask
endmodule

// ### verif/nacs_top_tb_top.sv
// Purpose: self-checking bench of the command sequencer.
// Assumes: short self-timed counts, ECC off unless a test sets it.
// Notes:   pages programmed upward within one block only.
`timescale 1ns/1ns
module nacs_top_tb_top;
  import nacs_pkg::*;
  localparam int unsigned PCYC = 3000;
  logic       clk_in, rst_in, sclk, cs_n, busy, write_enable_latch;
  logic [3:0] io_h, io_d, io_oe, io_w;
  logic [7:0] rdata, rx;
  logic [7:0] got [0:2175];
  logic [23:0] er_page;
  nacs_cfg_s  cfg;
  nacs_arr_s  arr;
  int         n_fail, n_checks, n_wr, n_er, cyc;
  // Shared data pin: device owns io1 only while enabled
  assign io_w = io_oe[1] ? {io_h[3:2], io_d[1], io_h[0]} : io_h;
  nacs_top #(.ERASE_CYC(PCYC), .PROG_CYC(PCYC)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .io_in(io_w), .io_out(io_d), .io_oe_out(io_oe), .cfg_in(cfg), .busy_out(busy),
    .write_enable_latch_out(write_enable_latch), .arr_out(arr), .arr_rdata_in(rdata));
  nacs_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .io_out(io_h), .io_in(io_w));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Array model: read data next cycle, writes into a shadow page
  always @(posedge clk_in) if (arr.rd) rdata <= arr.col[7:0] ^ 8'h5A;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (arr.wr) got[arr.col] <= arr.wdata;
    if (arr.wr) n_wr <= n_wr + 1;
    if (arr.erase) n_er <= n_er + 1;
    if (arr.erase) er_page <= arr.page;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic tx(input logic [7:0] b[$], input int qf = 99);
    i_host.frame(b, qf, rx);
  endtask
  // Bounded wait; a stuck busy counts as a mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(negedge clk_in);
      n++;
    end
    check(n < 4000, 1, "busy stuck");
  endtask
  task automatic prog(input logic [7:0] p);
    n_wr = 0;
    tx('{OP_WREN});
    tx('{OP_PEXEC, 8'h00, 8'h01, p});
    wait_idle();
    check(n_wr, BUF_BYTES, "write count");
    check(write_enable_latch, 0, "latch after exec");
  endtask
  task automatic s_erase();
    tx('{OP_WREN});
    tx('{OP_WRDI});
    check(write_enable_latch, 0, "latch after disable");
    tx('{OP_ERASE, 8'h00, 8'h01, 8'h40});
    check(busy, 0, "erase without latch");
    tx('{OP_WREN});
    check(write_enable_latch, 1, "latch set");
    tx('{OP_ERASE, 8'h00, 8'h01, 8'h40, 8'h00});
    check(busy, 0, "long erase frame");
    tx('{OP_ERASE, 8'h00, 8'h01, 8'h40});
    check(busy, 1, "erase busy");
    tx('{OP_RDSR_A, 8'hC0, 8'h00});
    check(rx[SR3_BSY_BIT], 1, "status busy bit");
    n_wr = 0;
    tx('{OP_PEXEC, 8'h00, 8'h01, 8'h41});
    wait_idle();
    check(n_wr, 0, "exec while busy");
    check(n_er, 1, "erase pulse");
    check(er_page, 24'h000140, "erase page");
    check(write_enable_latch, 0, "latch after erase");
  endtask
  task automatic s_load();
    tx('{OP_WREN});
    tx('{OP_LOAD, 8'h00, 8'h00, 8'hA5, 8'h3C});
    prog(8'h41);
    check({got[0], got[1], got[2], got[2175]}, 32'hA53CFFFF, "full load");
    tx('{OP_LOAD, 8'h00, 8'h00, 8'h11});
    prog(8'h42);
    check(got[0], 8'hA5, "load without latch");
  endtask
  task automatic s_read();
    tx('{OP_PREAD, 8'h00, 8'h01, 8'h40});
    check(busy, 1, "read busy");
    wait_idle();
    tx('{OP_WREN});
    tx('{OP_RLOAD, 8'hF8, 8'h7F, 8'h12, 8'h34});
    prog(8'h43);
    check({got[0], got[1], got[2175]}, 24'h5A5B12, "random load");
  endtask
  task automatic s_quad();
    @(negedge clk_in) cfg.wp_enable = 1'b1;
    tx('{OP_WREN});
    tx('{OP_QLOAD, 8'h00, 8'h00, 8'hC3}, 3);
    prog(8'h44);
    check(got[0], 8'h5A, "quad refused");
    @(negedge clk_in) cfg.wp_enable = 1'b0;
    tx('{OP_WREN});
    tx('{OP_QLOAD, 8'h00, 8'h00, 8'hC3}, 3);
    prog(8'h45);
    check({got[0], got[1]}, 16'hC3FF, "quad load");
  endtask
  task automatic s_ecc_prot();
    @(negedge clk_in) cfg.ecc_enable = 1'b1;
    tx('{OP_WREN});
    tx('{OP_LOAD, 8'h08, 8'h5F, 8'h11, 8'h22});
    prog(8'h46);
    check({got[2143], got[2144], got[2175]}, 24'h113333, "parity");
    @(negedge clk_in) {cfg.block_protect_bit3, cfg.block_protect_bit2} = 2'b11;
    tx('{OP_WREN});
    tx('{OP_ERASE, 8'h00, 8'h01, 8'h40});
    check(busy, 0, "protected erase busy");
    check(n_er, 1, "protected erase pulse");
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {n_fail, n_checks, n_wr, n_er, cyc} = '0;
    rst_in = 1'b1;
    cfg = '0;
    rdata = 8'h00;
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (6) @(negedge clk_in);
    check({busy, write_enable_latch, arr.erase, arr.wr, arr.rd, arr.col}, 0, "reset state");
    s_erase();
    s_load();
    s_read();
    s_quad();
    s_ecc_prot();
    conclude();
  end
endmodule
